//--- iop_pin_model.sv
// Pin-side model: external drivers, weak pulls and floating pins
`timescale 1ns/10ps
module iop_pin_model (
    input  wire        clk,
    input  wire [15:0] pin_out,
    input  wire [15:0] oe_n,
    input  wire [15:0] pu,
    input  wire [15:0] pd,
    input  wire [15:0] ext_en,
    input  wire [15:0] ext_val,
    output logic [15:0] pin_in
);
    integer i;
    initial pin_in = 16'h0000;
    // ============================================================
    // Pin level; a floating pin toggles so it never looks settled
    always @(posedge clk) begin
        for (i = 0; i < 16; i = i + 1) begin
            pin_in[i] <= !oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pu[i] ? 1'b1 : pd[i] ? 1'b0 : ~pin_in[i];
        end
    end
endmodule // iop_pin_model

//--- iop_port.v
// I/O port with analog select, atomic aliases, change notification and pin remap
`timescale 1ns/10ps
`include "iop_port_defs.vh"

module iop_port #(
    parameter NIN = 24
) (
    input  wire        CLK_SYS,
    input  wire        RST,
    input  wire        CE,
    input  wire [9:0]  ADDRESS,
    input  wire        READ,
    input  wire        WRITE,
    input  wire [31:0] WRITEDATA,
    output reg  [31:0] READDATA,
    output reg         WAITREQUEST,
    input  wire [15:0] PIN_IN,
    output reg  [15:0] PIN_OUT,
    output reg  [15:0] PIN_OE_N,
    output reg  [15:0] PULLUP_EN,
    output reg  [15:0] PULLDOWN_EN,
    input  wire [15:0] PERIPH_OUT,
    output reg  [NIN-1:0] PERIPH_IN,
    output reg  [15:0] ANALOG_EN,
    output reg         CHANGE_IRQ
);

// ============================================================
// State
reg  [15:0]    ana;
reg  [15:0]    dir;
reg  [15:0]    lat;
reg  [15:0]    cnen;
reg  [15:0]    cnst;
reg  [15:0]    pu;
reg  [15:0]    pd;
reg            cn_on;
reg            lock;
reg  [3:0]     in_sel [0:NIN-1];
reg  [NIN-1:0] in_assigned;
reg  [3:0]     out_sel [0:15];
reg  [15:0]    pin_meta;
reg  [15:0]    pin_sync;
reg  [15:0]    pin_prev;
reg  [31:0]    next_rdata;
integer        k;
integer        m;

// ============================================================
// Next values of the control registers
reg  [15:0]    next_ana;
reg  [15:0]    next_dir;
reg  [15:0]    next_lat;
reg  [15:0]    next_cnen;
reg  [15:0]    next_pu;
reg  [15:0]    next_pd;
reg            next_cn_on;
reg            next_lock;

// ============================================================
// Bus decode
wire           req       = READ | WRITE;
wire           accept    = req & ~WAITREQUEST;
wire           low_area  = (ADDRESS[9:8] == 2'b00);
wire [3:0]     grp       = ADDRESS[7:4];
wire [1:0]     op        = ADDRESS[3:2];
wire           in_area   = (ADDRESS[9:7] == `IOP_AREA_INSEL) && (ADDRESS[6:2] < NIN);
wire           out_area  = (ADDRESS[9:7] == `IOP_AREA_OUTSEL) && !ADDRESS[6];
wire [4:0]     in_idx    = ADDRESS[6:2];
wire [3:0]     out_idx   = ADDRESS[5:2];
wire           wr_ok     = accept & WRITE;
wire [15:0]    wd        = WRITEDATA[15:0];

function [15:0] alias_apply;
    input [15:0] old;
    input [15:0] d;
    input [1:0]  aop;
    begin
        case (aop)
            `IOP_OP_CLR: alias_apply = old & ~d;
            `IOP_OP_SET: alias_apply = old | d;
            `IOP_OP_INV: alias_apply = old ^ d;
            default:     alias_apply = d;
        endcase
    end
endfunction

// ============================================================
// Pin view and change detection
// Analog inputs read low whatever the pin voltage
wire [15:0]    analog_in  = ana & dir;                                          // [R05]
wire [15:0]    port_view  = pin_sync & ~analog_in;                              // [R05] [R23]
wire           port_read  = accept & READ & low_area & (grp == `IOP_GRP_PORT) & (op == `IOP_OP_WRITE);
wire [15:0]    changed;
wire [15:0]    next_cnst;
genvar gc;
generate
    for (gc = 0; gc < 16; gc = gc + 1) begin : g_chg
        // Edge seen only after both sync stages
        assign changed[gc]   = (pin_sync[gc] ^ pin_prev[gc]) & cn_on;           // [R07]
        // Set wins over the clearing read in the same cycle
        assign next_cnst[gc] = (cnst[gc] & ~port_read) | changed[gc];           // [R09]
    end
endgenerate
// Clocks stopped in sleep are not modelled; detection needs CLK_SYS
wire           next_irq   = |(cnen & next_cnst);                                // [R08] [R25]

// ============================================================
// Read mux
always @* begin
    next_rdata = 32'h0000_0000;
    if (low_area) begin
        if (op == `IOP_OP_WRITE) begin                                          // [R13]
            case (grp)
                `IOP_GRP_ANALOG: next_rdata = {16'h0000, ana};
                `IOP_GRP_DIR:    next_rdata = {16'h0000, dir};
                `IOP_GRP_PORT:   next_rdata = {16'h0000, port_view};             // [R23]
                `IOP_GRP_LATCH:  next_rdata = {16'h0000, lat};
                `IOP_GRP_CNEN:   next_rdata = {16'h0000, cnen};
                `IOP_GRP_CNSTAT: next_rdata = {16'h0000, cnst};
                `IOP_GRP_PULLUP: next_rdata = {16'h0000, pu};
                `IOP_GRP_PULLDN: next_rdata = {16'h0000, pd};
                `IOP_GRP_CNCON:  next_rdata = {16'h0000, cn_on, 15'h0000};
                `IOP_GRP_LOCK:   next_rdata = {31'h0000_0000, lock};
                default:         next_rdata = 32'h0000_0000;
            endcase
        end
    end else if (in_area) begin
        next_rdata = {28'h000_0000, in_sel[in_idx]};
    end else if (out_area) begin
        next_rdata = {28'h000_0000, out_sel[out_idx]};
    end
end

// ============================================================
// Register write decode
wire [15:0]    cncon_word = alias_apply({cn_on, 15'h0000}, wd, op);
wire [15:0]    lock_word  = alias_apply({15'h0000, lock}, wd, op);
wire           base_wr    = wr_ok & low_area;
// Locked writes still finish on the bus, contents untouched
wire           in_wr      = wr_ok & in_area & ~lock;                            // [R24]
wire           out_wr     = wr_ok & out_area & ~lock;                           // [R24]

always @* begin
    next_ana   = ana;
    next_dir   = dir;
    next_lat   = lat;
    next_cnen  = cnen;
    next_pu    = pu;
    next_pd    = pd;
    next_cn_on = cn_on;
    next_lock  = lock;
    if (base_wr) begin
        case (grp)
            `IOP_GRP_ANALOG: next_ana   = alias_apply(ana, wd, op);             // [R12]
            `IOP_GRP_DIR:    next_dir   = alias_apply(dir, wd, op);             // [R12]
            // Port writes land in the latch, never on the pin view
            `IOP_GRP_PORT:   next_lat   = alias_apply(lat, wd, op);             // [R23]
            `IOP_GRP_LATCH:  next_lat   = alias_apply(lat, wd, op);             // [R12]
            `IOP_GRP_CNEN:   next_cnen  = alias_apply(cnen, wd, op);            // [R08]
            `IOP_GRP_PULLUP: next_pu    = alias_apply(pu, wd, op);              // [R10]
            `IOP_GRP_PULLDN: next_pd    = alias_apply(pd, wd, op);              // [R10]
            `IOP_GRP_CNCON:  next_cn_on = cncon_word[`IOP_CNCON_ON_BIT];
            `IOP_GRP_LOCK:   next_lock  = lock_word[`IOP_LOCK_BIT];
            // Status is read-only; unmapped groups drop the write
            default: begin
            end
        endcase
    end
end

// ============================================================
// Configuration registers
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        ana  <= `IOP_ANALOG_RESET;                                              // [R03]
        dir  <= `IOP_DIR_RESET;                                                 // [R22]
        lat  <= 16'h0000;
        pu   <= 16'h0000;
        pd   <= 16'h0000;
        lock <= 1'b0;
    end else if (CE) begin
        ana  <= next_ana;
        dir  <= next_dir;
        lat  <= next_lat;
        pu   <= next_pu;
        pd   <= next_pd;
        lock <= next_lock;
    end
end

// ============================================================
// Change notification registers
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        cnen       <= 16'h0000;
        cnst       <= 16'h0000;
        cn_on      <= 1'b0;
        CHANGE_IRQ <= 1'b0;
    end else if (CE) begin
        cnen       <= next_cnen;
        cnst       <= next_cnst;
        cn_on      <= next_cn_on;
        // Level request, follows status and enable
        CHANGE_IRQ <= next_irq;                                                 // [R25]
    end
end

// ============================================================
// Input selectors
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        in_assigned <= {NIN{1'b0}};                                             // [R14]
        for (k = 0; k < NIN; k = k + 1) begin
            in_sel[k] <= `IOP_SEL_RESET;
        end
    end else if (CE) begin
        if (in_wr) begin
            in_sel[in_idx]      <= WRITEDATA[3:0];                              // [R17]
            in_assigned[in_idx] <= 1'b1;                                        // [R14]
        end
    end
end

// ============================================================
// Output selectors
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        for (m = 0; m < 16; m = m + 1) begin
            out_sel[m] <= `IOP_SEL_RESET;                                       // [R20]
        end
    end else if (CE) begin
        if (out_wr) begin
            out_sel[out_idx] <= WRITEDATA[3:0];                                 // [R19]
        end
    end
end

// ============================================================
// Pin synchroniser and change history
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        pin_meta <= 16'h0000;
        pin_sync <= 16'h0000;
        pin_prev <= 16'h0000;
    end else if (CE) begin
        // Only the second and third stages feed logic; the first may be metastable
        pin_meta <= PIN_IN;
        pin_sync <= pin_meta;
        pin_prev <= pin_sync;
    end
end

// ============================================================
// Bus handshake
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        WAITREQUEST <= 1'b1;
        READDATA    <= 32'h0000_0000;
    end else if (CE) begin
        // One wait state: data is ready when waitrequest falls
        if (accept) begin
            WAITREQUEST <= 1'b1;
        end else if (req) begin
            WAITREQUEST <= 1'b0;
            READDATA    <= next_rdata;
        end
    end
end

// ============================================================
// Output remap, per pin
wire [15:0] next_pin_out;
wire [15:0] next_oe_n;
genvar gp;
generate
    for (gp = 0; gp < 16; gp = gp + 1) begin : g_out
        wire [3:0] s     = out_sel[gp];
        wire       pbit  = PERIPH_OUT[s];
        // Analog keeps the pin; remap only acts on digital pins
        wire       remap = (s != 4'h0) && !ana[gp];                             // [R16] [R20]
        // Analog pin with direction cleared still shows the latch level
        assign next_pin_out[gp] = remap ? pbit : lat[gp];                       // [R15] [R04]
        assign next_oe_n[gp]    = remap ? 1'b0 : dir[gp];                       // [R15] [R22]
    end
endgenerate

// ============================================================
// Input remap, per peripheral input
wire [NIN-1:0] next_periph_in;
genvar gi;
generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_in
        localparam [1:0] GRP = (gi < `IOP_GRP1_FIRST) ? 2'd0 :
                               (gi < `IOP_GRP2_FIRST) ? 2'd1 :
                               (gi < `IOP_GRP3_FIRST) ? 2'd2 : 2'd3;
        wire [3:0] s   = in_sel[gi];
        // Eight candidates per group; groups overlap on a 16-pin port
        wire [3:0] pin = {GRP, 2'b00} + {1'b0, s[2:0]};                         // [R18]
        // Analog pins feed no peripheral
        wire       lvl = pin_sync[pin] & ~ana[pin];                             // [R16]
        assign next_periph_in[gi] = in_assigned[gi] & ~s[3] & lvl;              // [R14] [R18] [R21]
    end
endgenerate

// ============================================================
// Registered pin-side outputs
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        PIN_OUT  <= 16'h0000;
        PIN_OE_N <= 16'hFFFF;
    end else if (CE) begin
        PIN_OUT  <= next_pin_out;
        PIN_OE_N <= next_oe_n;
    end
end

// ============================================================
// Registered pull enables
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        PULLUP_EN   <= 16'h0000;
        PULLDOWN_EN <= 16'h0000;
    end else if (CE) begin
        PULLUP_EN   <= pu;                                                      // [R10]
        PULLDOWN_EN <= pd;                                                      // [R10]
    end
end

// ============================================================
// Registered peripheral-side outputs
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        PERIPH_IN <= {NIN{1'b0}};
        ANALOG_EN <= `IOP_ANALOG_RESET;
    end else if (CE) begin
        PERIPH_IN <= next_periph_in;
        ANALOG_EN <= ana;
    end
end

endmodule // iop_port

//--- iop_port_asserts.sv
// Checker of bus handshake, reset state and readback of the I/O port
`timescale 1ns/10ps
module iop_port_asserts #(
    parameter NIN = 24
) (
    input wire           CLK_SYS,
    input wire           RST,
    input wire [9:0]     ADDRESS,
    input wire           READ,
    input wire           WRITE,
    input wire [31:0]    READDATA,
    input wire           WAITREQUEST,
    input wire [15:0]    PIN_OE_N,
    input wire [NIN-1:0] PERIPH_IN,
    input wire [15:0]    ANALOG_EN,
    input wire           CHANGE_IRQ
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // ============================================================
    // Handshake
    a_one_wait: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
        else $error("request not answered after one wait state");
    a_ack_once: assert property (!WAITREQUEST |=> WAITREQUEST)
        else $error("acknowledge longer than one cycle");
    a_ack_cause: assert property (!WAITREQUEST |-> (READ || WRITE) && $past(READ || WRITE))
        else $error("acknowledge without request");
    // ============================================================
    // Reset state and readback
    a_reset_state: assert property ($fell(RST) |-> ANALOG_EN == 16'hFFFF && PIN_OE_N == 16'hFFFF
        && PERIPH_IN == '0 && !CHANGE_IRQ) else $error("wrong state after reset");
    a_alias_zero: assert property (READ && !WAITREQUEST && ADDRESS[9:8] == 2'h0 && ADDRESS[3:2] != 2'h0
        |-> READDATA == 32'h0) else $error("alias read not zero");
    a_upper_zero: assert property (READ && !WAITREQUEST |-> READDATA[31:16] == 16'h0)
        else $error("upper read bits not zero");
    a_unmapped_zero: assert property (READ && !WAITREQUEST && ADDRESS[9:8] == 2'h0 && ADDRESS[7:4] > 4'h9
        |-> READDATA == 32'h0) else $error("unmapped read not zero");
    a_analog_zero: assert property (READ && !WAITREQUEST && ADDRESS == 10'h020
        |-> (READDATA[15:0] & ANALOG_EN & PIN_OE_N) == 16'h0) else $error("analog input read not zero");
endmodule // iop_port_asserts

bind iop_port iop_port_asserts #(.NIN(NIN)) iop_port_asserts_inst (
    .CLK_SYS(CLK_SYS), .RST(RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .PIN_OE_N(PIN_OE_N),
    .PERIPH_IN(PERIPH_IN), .ANALOG_EN(ANALOG_EN), .CHANGE_IRQ(CHANGE_IRQ));

//--- iop_port_bench.sv
// Self-checking bench of the I/O port over its register bus
`timescale 1ns/10ps
module iop_port_bench;
    logic        clk = 0, rst = 1, rd = 0, wr_s = 0, ce = 1, wreq, irq;
    logic [9:0]  adr = 0;
    logic [31:0] wd = 0, rdata, q;
    logic [15:0] pin_in, pin_out, oe_n, pu, pd, aen, pout = 0, ext_val = 0, ext_en = 16'hFFFF;
    logic [23:0] per;
    integer      bad_count = 0, comparisons = 0;
    always #25 clk = ~clk;
    iop_port #(.NIN(24)) iop_port_inst (.CLK_SYS(clk), .RST(rst), .CE(ce), .ADDRESS(adr), .READ(rd),
        .WRITE(wr_s), .WRITEDATA(wd), .READDATA(rdata), .WAITREQUEST(wreq), .PIN_IN(pin_in),
        .PIN_OUT(pin_out), .PIN_OE_N(oe_n), .PULLUP_EN(pu), .PULLDOWN_EN(pd), .PERIPH_OUT(pout),
        .PERIPH_IN(per), .ANALOG_EN(aen), .CHANGE_IRQ(irq));
    iop_pin_model iop_pin_model_inst (.clk(clk), .pin_out(pin_out), .oe_n(oe_n), .pu(pu), .pd(pd),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    // ============================================================
    // Tasks
    task print_verdict;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Request held until waitrequest is sampled low
    task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        integer n;
        begin
            @(posedge clk);
            adr <= a;
            wd <= d;
            wr_s <= w;
            rd <= !w;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
            end while (wreq !== 1'b0 && n < 20);
            q = rdata;
            rd <= 0;
            wr_s <= 0;
            if (n >= 20) begin
                bad_count = bad_count + 1;
                print_verdict();
            end
        end
    endtask
    task wr(input logic [9:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
    task rc(input logic [9:0] a, input logic [31:0] e); begin bus(1'b0, a, 32'h0); chk(q, e); end endtask
    task tick(input integer n); repeat (n) @(posedge clk); endtask
    // ============================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        rc(10'h000, 32'hFFFF);
        rc(10'h010, 32'hFFFF);
        rc(10'h180, 32'h0);
        chk({8'h0, per}, 32'h0);
        wr(10'h030, 32'hA5A5);
        wr(10'h034, 32'h00FF);
        rc(10'h030, 32'hA500);
        wr(10'h038, 32'h000F);
        rc(10'h030, 32'hA50F);
        wr(10'h03C, 32'hFFFF);
        rc(10'h030, 32'h5AF0);
        rc(10'h03C, 32'h0);
        wr(10'h004, 32'hFFFF);
        wr(10'h014, 32'h00FF);
        ext_val <= 16'h5A00;
        tick(4);
        chk({16'h0, oe_n}, 32'hFF00);
        rc(10'h020, 32'h5AF0);
        wr(10'h020, 32'h1234);
        rc(10'h030, 32'h1234);
        wr(10'h008, 32'h000F);
        wr(10'h018, 32'h0003);
        ext_val <= 16'h5A03;
        tick(4);
        chk({16'h0, oe_n}, 32'hFF03);
        chk({16'h0, aen}, 32'h000F);
        rc(10'h020, 32'h5A34);
        wr(10'h060, 32'h0C00);
        wr(10'h070, 32'h3000);
        tick(2);
        chk({pd, pu}, 32'h30000C00);
        wr(10'h080, 32'h8000);
        wr(10'h040, 32'h0100);
        rc(10'h020, 32'h5A34);
        ext_val <= 16'h5803;
        tick(8);
        chk({31'h0, irq}, 32'h0);
        rc(10'h050, 32'h0200);
        ext_val <= 16'h5903;
        tick(8);
        chk({31'h0, irq}, 32'h1);
        tick(10);
        chk({31'h0, irq}, 32'h1);
        rc(10'h020, 32'h5934);
        tick(4);
        chk({31'h0, irq}, 32'h0);
        rc(10'h050, 32'h0);
        wr(10'h13C, 32'h3);
        ext_val <= 16'h5B03;
        tick(5);
        chk({31'h0, per[15]}, 32'h1);
        wr(10'h13C, 32'h8);
        tick(5);
        chk({31'h0, per[15]}, 32'h0);
        wr(10'h13C, 32'h3);
        wr(10'h100, 32'h2);
        tick(5);
        chk({31'h0, per[0]}, 32'h0);
        wr(10'h194, 32'h3);
        wr(10'h188, 32'h3);
        tick(3);
        chk({31'h0, pin_out[5]}, 32'h0);
        pout <= 16'h0008;
        tick(3);
        chk({30'h0, pin_out[5], per[15]}, 32'h3);
        chk({31'h0, pin_out[2]}, 32'h1);
        ce <= 0;
        pout <= 16'h0000;
        tick(3);
        chk({31'h0, pin_out[5]}, 32'h1);
        ce <= 1;
        tick(3);
        chk({31'h0, pin_out[5]}, 32'h0);
        wr(10'h090, 32'h1);
        wr(10'h13C, 32'h5);
        rc(10'h13C, 32'h3);
        wr(10'h090, 32'h0);
        wr(10'h0A0, 32'hFFFF);
        rc(10'h0A0, 32'h0);
        print_verdict();
    end
endmodule // iop_port_bench

//--- iop_port_defs.vh
// Constants for the I/O port with pin remap: offsets, field positions, reset values
//
// How it works
// R01: Software sets analog select and direction before using a pin as analog input.
// R02: Software clears analog select before a pin serves digital peripherals or I/O.
// R03: Analog select register resets to all ones, every shared pin analog.
// R04: Analog pin with direction cleared still drives the output latch level.
// R05: Pin-level port reads zero on pins set as analog input channels.
// R06: Software waits one instruction between direction or latch write and port read.
// R07: Change on a selected input pin raises the change interrupt request.
// R08: Each pin's change enable bit gates its own interrupt contribution only.
// R09: Change status records a pin change since the last pin-level port read.
// R10: Per-pin weak pull-up and pull-down enables, each set independently.
// R11: Software keeps pulls disabled on pins used as digital outputs.
// R12: Clear, set and invert aliases modify only base bits written as one.
// R13: Alias reads are undefined; the base register shows the effect.
// R14: Remappable peripheral inputs stay unconnected until software assigns a pin.
// R15: Active remapped output overrides general I/O on that pin.
// R16: Analog selection keeps priority over any remapped peripheral.
// R17: Each peripheral input owns a 4-bit selector choosing its pin.
// R18: Four input groups of eight pins; codes 1000 to 1111 reserved.
// R19: Each remappable pin owns a 4-bit selector choosing its peripheral output.
// R20: Output selector zero, the reset value, connects no peripheral.
// R21: Input and output mapping are controlled independently.
// R22: Direction bit one means input; all pins reset as inputs.
// R23: Pin-level port reads pins, writes go to the output latch.
// R24: While the remap lock is set, selector writes complete but change nothing.
// R25: Change interrupt stays high while any pin has enable and status set.
`ifndef IOP_PORT_DEFS_VH
`define IOP_PORT_DEFS_VH

// ============================================================
// Register groups (address bits 7:4 below 0x100)
`define IOP_GRP_ANALOG     4'h0
`define IOP_GRP_DIR        4'h1
`define IOP_GRP_PORT       4'h2
`define IOP_GRP_LATCH      4'h3
`define IOP_GRP_CNEN       4'h4
`define IOP_GRP_CNSTAT     4'h5
`define IOP_GRP_PULLUP     4'h6
`define IOP_GRP_PULLDN     4'h7
`define IOP_GRP_CNCON      4'h8
`define IOP_GRP_LOCK       4'h9

// ============================================================
// Alias operation (address bits 3:2)
`define IOP_OP_WRITE       2'h0
`define IOP_OP_CLR         2'h1
`define IOP_OP_SET         2'h2
`define IOP_OP_INV         2'h3

// ============================================================
// Selector areas (address bits 9:7)
`define IOP_AREA_INSEL     3'h2
`define IOP_AREA_OUTSEL    3'h3

// ============================================================
// Field positions and reset values
`define IOP_CNCON_ON_BIT   15
`define IOP_LOCK_BIT       0
`define IOP_ANALOG_RESET   16'hFFFF
`define IOP_DIR_RESET      16'hFFFF
`define IOP_SEL_RESET      4'h0

// ============================================================
// First input index of input groups 1, 2 and 3
`define IOP_GRP1_FIRST     5
`define IOP_GRP2_FIRST     11
`define IOP_GRP3_FIRST     19

`endif
